// [logic/cim_map.svh]
// register map, field positions and reset values of the interrupt masking block
// Summary of operation
// - separate cpu enable bit per source, three registers
// - multi-event peripheral flags need one mask bit
// - audio block has its own enable bits
// - global enable bit in first enable register
// - global enable low blocks every interrupt
// - sources 0..17 vector to 0x03 plus 8n
// - listed flags cleared by hardware on vectoring
// - audio receive shares source 3, vector 0x1b
// - audio transmit shares source 14, vector 0x73
// - usb pending shares source 6, vector 0x33
// - usb resume arrives as port 0 pin 7
// - watchdog flags only on overflow in timer mode
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH

// apb byte offsets
`define CIM_OFS_EN_A      8'h00
`define CIM_OFS_EN_B      8'h04
`define CIM_OFS_EN_C      8'h08
`define CIM_OFS_FLAG      8'h0c
`define CIM_OFS_AUD_EN    8'h10
`define CIM_OFS_MASK_BASE 8'h20
`define CIM_MASK_COUNT    9

// reset values
`define CIM_RST_EN        8'h00
`define CIM_RST_FLAG      18'h00000
`define CIM_RST_AUD_EN    2'h0
`define CIM_RST_MASK      8'h00

// field positions
`define CIM_GLOBAL_BIT    7
`define CIM_EN_B_RO_BIT   6
`define CIM_AUD_RX_BIT    0
`define CIM_AUD_TX_BIT    1
`define CIM_P0_RESUME_BIT 7

// source numbers
`define CIM_SRC_RADIO     0
`define CIM_SRC_SER1_RX   3
`define CIM_SRC_PORT2     6
`define CIM_SRC_PORT0     13
`define CIM_SRC_SER1_TX   14
`define CIM_SRC_WDOG      17

// flags cleared by hardware when the cpu vectors (0..3, 9..12)
`define CIM_HW_CLR_MASK   18'h01e0f

// vector arithmetic
`define CIM_VEC_BASE      8'h03
`define CIM_VEC_SHIFT     3

`endif

// [logic/cim_pkg.sv]
// types and shared functions of the interrupt masking block
`include "cim_map.svh"
package cim_pkg;

    typedef logic [17:0] cim_src_t;
    typedef logic [4:0]  cim_num_t;
    typedef logic [7:0]  cim_vec_t;

    // vector address of a source number
    function automatic cim_vec_t cim_vec_f(input cim_num_t n);
        cim_vec_f = `CIM_VEC_BASE + (cim_vec_t'(n) << `CIM_VEC_SHIFT);
    endfunction

endpackage

// [logic/cim_req_if.sv]
// carrier between the request gate and the vector selector
`timescale 1ns/1ps
interface cim_req_if;
    import cim_pkg::*;

    cim_src_t req;
    logic     any;
    cim_num_t num;
    cim_vec_t vec;

    modport gate (output req, input any, input num, input vec);
    modport sel  (input req, output any, output num, output vec);
endinterface

// [logic/cim_top.sv]
// cpu interrupt masking, flag keeping and vector selection
`timescale 1ns/1ps
`include "cim_map.svh"
module cim_top
    import cim_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // single event sources
    input  wire logic        RADIO_DONE_I,
    input  wire logic        ADC_DONE_I,
    input  wire logic        SER0_RX_I,
    input  wire logic        SER1_RX_I,
    input  wire logic        ENC_DONE_I,
    input  wire logic        SLEEP_CMP_I,
    input  wire logic        SER0_TX_I,
    input  wire logic        SER1_TX_I,
    // shared sources
    input  wire logic        AUD_RX_I,
    input  wire logic        AUD_TX_I,
    input  wire logic        USB_PEND_I,
    input  wire logic        USB_RESUME_I,
    // watchdog
    input  wire logic        WDOG_OVF_I,
    input  wire logic        WDOG_TMODE_I,
    // multi event peripherals, 8 events each
    input  wire logic [71:0] MEV_I,
    // cpu side
    input  wire logic        CPU_ACK_I,
    input  wire logic [4:0]  CPU_ACK_NUM_I,
    output logic             IRQ_O,
    output logic      [4:0]  IRQ_NUM_O,
    output logic      [7:0]  IRQ_VEC_O
);

    logic [7:0]  en_a_r;
    logic [7:0]  en_b_r;
    logic [7:0]  en_c_r;
    cim_src_t    flag_r;
    cim_src_t    flag_nxt;
    logic [1:0]  aud_en_r;
    logic [7:0]  mask_r [`CIM_MASK_COUNT];
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        irq_r;
    cim_num_t    num_r;
    cim_vec_t    vec_r;
    cim_src_t    en_all;
    cim_src_t    set_ev;
    cim_src_t    sw_clr;
    cim_src_t    hw_clr;
    logic [8:0]  mev_hit;
    logic [71:0] mev_ev;
    logic        apb_wr;
    logic        apb_setup_acc;
    logic [31:0] rdata;
    logic        hit;

    cim_req_if rq ();

    cim_vec_sel cim_vec_sel_i
    (
        .rq (rq.sel)
    );

    // byte address of a mask register
    function automatic logic [7:0] mask_ofs_f(input int k);
        mask_ofs_f = `CIM_OFS_MASK_BASE + 8'(k * 4);
    endfunction

    // enable bits gathered in source order, one per source
    assign en_all = {en_c_r[5], en_c_r[0], en_c_r[4], en_c_r[3], en_b_r[5],
                     en_b_r[4], en_b_r[3], en_b_r[2], en_b_r[1], en_b_r[0],
                     en_c_r[2], en_c_r[1], en_a_r[5:0]};

    // usb resume arrives as the pin 7 event of port 0
    assign mev_ev = MEV_I | {64'h0, USB_RESUME_I, 7'h00};

    // a peripheral flags only through its own mask bits
    always_comb
    begin
        for (int k = 0; k < `CIM_MASK_COUNT; k++)
        begin
            mev_hit[k] = |(mev_ev[8*k +: 8] & mask_r[k]);
        end
    end

    // event to source mapping, shared vectors folded in
    always_comb
    begin
        set_ev     = {WDOG_OVF_I & WDOG_TMODE_I,
                      mev_hit[8], mev_hit[1],
                      SER1_TX_I | (AUD_TX_I & aud_en_r[`CIM_AUD_TX_BIT]),
                      mev_hit[0], mev_hit[7], mev_hit[6], mev_hit[5],
                      mev_hit[4], mev_hit[3], SER0_TX_I,
                      mev_hit[2] | USB_PEND_I,
                      SLEEP_CMP_I, ENC_DONE_I,
                      SER1_RX_I | (AUD_RX_I & aud_en_r[`CIM_AUD_RX_BIT]),
                      SER0_RX_I, ADC_DONE_I, RADIO_DONE_I};
    end

    // apb phase decode; one wait state, write lands on the completing edge
    assign apb_setup_acc = PSEL_I & PENABLE_I & ~pready_r;
    assign apb_wr        = PSEL_I & PENABLE_I & pready_r & PWRITE_I;

    // read mux and address hit
    always_comb
    begin
        rdata = 32'h0;
        hit   = 1'b1;
        case (PADDR_I)
            `CIM_OFS_EN_A:   rdata = {24'h0, en_a_r};
            `CIM_OFS_EN_B:   rdata = {24'h0, en_b_r};
            `CIM_OFS_EN_C:   rdata = {24'h0, en_c_r};
            `CIM_OFS_FLAG:   rdata = {14'h0, flag_r};
            `CIM_OFS_AUD_EN: rdata = {30'h0, aud_en_r};
            default:
            begin
                hit = 1'b0;
                for (int k = 0; k < `CIM_MASK_COUNT; k++)
                begin
                    if (PADDR_I == mask_ofs_f(k))
                    begin
                        rdata = {24'h0, mask_r[k]};
                        hit   = 1'b1;
                    end
                end
            end
        endcase
    end

    // apb answer, all outputs registered
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= apb_setup_acc;
            pslverr_r <= apb_setup_acc & ~hit;
            if (apb_setup_acc & ~PWRITE_I)
            begin
                prdata_r <= rdata;
            end
            else
            begin
                prdata_r <= 32'h0;
            end
        end
    end

    // cpu enable registers; global bit lives in the first
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            en_a_r <= `CIM_RST_EN;
            en_b_r <= `CIM_RST_EN;
            en_c_r <= `CIM_RST_EN;
        end
        else if (apb_wr)
        begin
            if (PADDR_I == `CIM_OFS_EN_A)
            begin
                en_a_r <= PWDATA_I[7:0];
            end
            if (PADDR_I == `CIM_OFS_EN_B)
            begin
                en_b_r <= PWDATA_I[7:0] & ~(8'h01 << `CIM_EN_B_RO_BIT);
            end
            if (PADDR_I == `CIM_OFS_EN_C)
            begin
                en_c_r <= PWDATA_I[7:0];
            end
        end
    end

    // audio enables and per-event masks
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            aud_en_r <= `CIM_RST_AUD_EN;
            for (int k = 0; k < `CIM_MASK_COUNT; k++)
            begin
                mask_r[k] <= `CIM_RST_MASK;
            end
        end
        else if (apb_wr)
        begin
            if (PADDR_I == `CIM_OFS_AUD_EN)
            begin
                aud_en_r <= PWDATA_I[1:0];
            end
            for (int k = 0; k < `CIM_MASK_COUNT; k++)
            begin
                if (PADDR_I == mask_ofs_f(k))
                begin
                    mask_r[k] <= PWDATA_I[7:0];
                end
            end
        end
    end

    // clears: software write-one, hardware on vectoring for listed flags
    assign sw_clr = (apb_wr && PADDR_I == `CIM_OFS_FLAG) ? PWDATA_I[17:0] : 18'h0;
    assign hw_clr = CPU_ACK_I ? (18'(18'h1 << CPU_ACK_NUM_I) & `CIM_HW_CLR_MASK)
                              : 18'h0;

    // a set in the clearing cycle survives
    assign flag_nxt = (flag_r & ~(sw_clr | hw_clr)) | set_ev;

    // cpu flags
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            flag_r <= `CIM_RST_FLAG;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    // request needs flag, own enable and global enable
    assign rq.req = flag_r & en_all & {18{en_a_r[`CIM_GLOBAL_BIT]}};

    // registered request, number and vector toward the cpu
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            irq_r <= 1'b0;
            num_r <= 5'h00;
            vec_r <= 8'h00;
        end
        else
        begin
            irq_r <= rq.any;
            num_r <= rq.num;
            vec_r <= rq.any ? rq.vec : 8'h00;
        end
    end

    assign PRDATA_O  = prdata_r;
    assign PREADY_O  = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign IRQ_O     = irq_r;
    assign IRQ_NUM_O = num_r;
    assign IRQ_VEC_O = vec_r;

    // checks on the block's own behaviour
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    a_global_gate_off: assert property (!en_a_r[7] |=> !IRQ_O)
        else $error("request raised with global enable low");

    a_req_all_three: assert property
        ((|(flag_r & en_all) && en_a_r[7]) |=> IRQ_O)
        else $error("pending enabled source not requested");

    a_vector_formula: assert property
        (IRQ_O |-> IRQ_VEC_O == 8'h03 + {IRQ_NUM_O, 3'h0})
        else $error("vector does not match source number");

    a_hw_clear_radio: assert property
        ((CPU_ACK_I && CPU_ACK_NUM_I == 5'd0 && !RADIO_DONE_I) |=> !flag_r[0])
        else $error("radio flag survived vectoring");

    a_wdog_flag_kept: assert property
        ((CPU_ACK_I && CPU_ACK_NUM_I == 5'd17 && flag_r[17] && sw_clr == 18'h0)
         |=> flag_r[17])
        else $error("watchdog flag cleared by vectoring");

    a_wdog_timer_mode: assert property
        ((!flag_r[17] && !WDOG_TMODE_I) |=> !flag_r[17])
        else $error("watchdog flag set outside timer mode");

    a_dma_masked: assert property
        ((!flag_r[8] && mask_r[3] == 8'h00) |=> !flag_r[8])
        else $error("dma flag set with all masks clear");

    a_aud_rx_shared: assert property
        ((AUD_RX_I && aud_en_r[0]) |=> flag_r[3])
        else $error("audio receive missed source 3");

    a_aud_tx_shared: assert property
        ((AUD_TX_I && aud_en_r[1]) |=> flag_r[14])
        else $error("audio transmit missed source 14");

    a_usb_pend_shared: assert property (USB_PEND_I |=> flag_r[6])
        else $error("usb pending missed source 6");

    a_usb_resume_p0: assert property
        ((USB_RESUME_I && mask_r[0][7]) |=> flag_r[13])
        else $error("usb resume missed source 13");

endmodule // cim_top

// [logic/cim_vec_sel.sv]
// picks the lowest numbered pending request and its vector
`timescale 1ns/1ps
module cim_vec_sel
    import cim_pkg::*;
(
    cim_req_if.sel rq
);

    // fixed order: lower number wins, priority groups not modelled
    always_comb
    begin
        rq.any = 1'b0;
        rq.num = 5'h00;
        for (int i = 17; i >= 0; i--)
        begin
            if (rq.req[i])
            begin
                rq.any = 1'b1;
                rq.num = 5'(i);
            end
        end
        rq.vec = cim_vec_f(rq.num);
    end

endmodule // cim_vec_sel

// [verification/cim_cpu_model.sv]
// cpu core model that vectors to pending requests of the masking block
`timescale 1ns/1ps
module cim_cpu_model
    import cim_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // request from the block
    input  wire logic       irq_i,
    input  wire cim_num_t   num_i,
    // which routines exist, and how slow the core is
    input  wire cim_src_t   isr_ok_i,
    input  wire logic [1:0] lat_i,
    // acknowledge toward the block
    output logic            ack_o,
    output cim_num_t        ack_num_o
);
    logic [1:0] wait_r;

    // vectors only where a service routine is present
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_o     <= 1'b0;
            ack_num_o <= 5'h00;
            wait_r    <= 2'h0;
        end
        else if (!ack_o && irq_i && isr_ok_i[num_i])
        begin
            // lat_i stretches the answer to mimic a busy core
            if (wait_r == lat_i)
            begin
                ack_o     <= 1'b1;
                ack_num_o <= num_i;
                wait_r    <= 2'h0;
            end
            else
            begin
                wait_r <= wait_r + 2'h1;
            end
        end
        else
        begin
            ack_o     <= 1'b0;
            wait_r    <= 2'h0;
            // number means nothing outside the pulse, so keep it moving
            ack_num_o <= ~ack_num_o;
        end
    end
endmodule // cim_cpu_model

// [verification/cim_top_tb.sv]
// self-checking bench of the interrupt masking block
`timescale 1ns/1ps
module cim_top_tb;
    logic        clk = 0;
    logic        rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0, tmode = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, ack;
    logic [12:0] ev = 0;
    logic [71:0] mev = 0;
    logic [4:0]  num, ack_num;
    logic [7:0]  vec;
    logic [17:0] isr_ok = 0;
    logic [1:0]  lat = 0;
    int          n_errors = 0, n_tests = 0, cyc = 0, n_ack = 0;

    always #20 clk = ~clk;

    cim_top cim_top_i (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RADIO_DONE_I(ev[0]), .ADC_DONE_I(ev[1]),
        .SER0_RX_I(ev[2]), .SER1_RX_I(ev[3]), .ENC_DONE_I(ev[4]), .SLEEP_CMP_I(ev[5]),
        .SER0_TX_I(ev[6]), .SER1_TX_I(ev[7]), .AUD_RX_I(ev[8]), .AUD_TX_I(ev[9]),
        .USB_PEND_I(ev[10]), .USB_RESUME_I(ev[11]), .WDOG_OVF_I(ev[12]),
        .WDOG_TMODE_I(tmode), .MEV_I(mev), .CPU_ACK_I(ack), .CPU_ACK_NUM_I(ack_num),
        .IRQ_O(irq), .IRQ_NUM_O(num), .IRQ_VEC_O(vec));

    cim_cpu_model cim_cpu_model_i (.clk_i(clk), .rst_i(rst), .irq_i(irq), .num_i(num),
        .isr_ok_i(isr_ok), .lat_i(lat), .ack_o(ack), .ack_num_o(ack_num));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, g, e);
        end
    endtask

    // one apb transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel   <= 1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(0, a, 0, r, e);
        chk(r, x);
    endtask

    // let flag and request registers land
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input logic [12:0] m, input logic [71:0] v);
        @(posedge clk);
        ev  <= m;
        mev <= v;
        @(posedge clk);
        ev  <= 0;
        mev <= 0;
        settle;
    endtask

    // level, vector and number of the request, vector reckoned as base plus 8n
    task automatic req(input logic q, input logic [4:0] n);
        chk({irq, vec}, {q, q ? 8'h03 + {n, 3'h0} : 8'h00});
        if (q)
            chk(num, n);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(8'h00, 0); // first enable register comes up cleared
        rd(8'h0c, 0); // no flag after reset
        wr(8'h04, 32'hff);
        rd(8'h04, 32'hbf); // spare bit 6 reads zero
        apb(0, 8'h14, 0, r, e);
        chk(e, 1); // hole in the map is refused
        chk(r, 0); // and reads zero
        wr(8'h04, 0);
        req(0, 0); // quiet after reset
    endtask

    task automatic t_gate;
        wr(8'h0c, 32'h3ffff); // flags cleared first
        wr(8'h00, 32'h02);
        pulse(13'h003, 0);
        rd(8'h0c, 32'h3); // both flags kept with global off
        req(0, 0); // nothing asked while global is off
        wr(8'h00, 32'h82); // global enable set last
        settle;
        req(1, 1); // masked radio flag ignored
        @(posedge clk);
        isr_ok <= 18'h00002;
        repeat (6) @(posedge clk);
        #1;
        req(0, 0); // request gone once vectored
        rd(8'h0c, 32'h1); // converter flag cleared by vectoring
        wr(8'h00, 32'h83);
        settle;
        req(1, 0); // first source at the lowest vector
        wr(8'h00, 32'h03);
        settle;
        req(0, 0); // global off silences a pending source
        @(posedge clk);
        isr_ok <= 18'h00001;
        wr(8'h00, 32'h81);
        repeat (6) @(posedge clk);
        #1;
        req(0, 0); // request gone once radio vectored
        rd(8'h0c, 0); // radio flag cleared by vectoring
        isr_ok <= 0;
        wr(8'h0c, 32'h3ffff);
    endtask

    task automatic t_mev;
        int         src[9] = '{13, 15, 6, 8, 9, 10, 11, 12, 16};
        logic [7:0] m;
        for (int k = 0; k < 9; k++)
        begin
            m = 8'h01 << (k % 8);
            pulse(0, {64'h0, 8'hff} << (8 * k));
            rd(8'h0c, 0); // no mask bit set keeps the flag low
            wr(8'(32'h20 + 4 * k), {24'h0, m});
            pulse(0, {64'h0, ~m} << (8 * k));
            rd(8'h0c, 0); // unmasked events raise nothing
            pulse(0, {64'h0, m} << (8 * k));
            rd(8'h0c, 32'h1 << src[k]); // masked event raises its source
            wr(8'h0c, 32'h3ffff);
        end
    endtask

    task automatic t_wdog;
        int a;
        pulse(13'h1000, 0);
        rd(8'h0c, 0); // overflow outside timer mode ignored
        @(posedge clk);
        tmode <= 1;
        pulse(13'h1000, 0);
        rd(8'h0c, 32'h20000); // overflow in timer mode flags
        wr(8'h08, 32'h20);
        wr(8'h00, 32'h80);
        settle;
        req(1, 17); // last source at the top vector
        a = n_ack;
        @(posedge clk);
        isr_ok <= 18'h20000;
        lat    <= 3;
        repeat (12) @(posedge clk);
        chk(n_ack > a, 1); // slow core did vector
        rd(8'h0c, 32'h20000); // this flag survives vectoring
        @(posedge clk);
        isr_ok <= 0;
        wr(8'h0c, 32'h3ffff);
        wr(8'h08, 0);
    endtask

    task automatic t_shared;
        pulse(13'h100, 0);
        rd(8'h0c, 0); // audio receive needs its own enable
        wr(8'h10, 32'h3);
        wr(8'h00, 32'h88);
        pulse(13'h100, 0);
        req(1, 3); // audio receive on the serial receive vector
        pulse(13'h200, 0);
        rd(8'h0c, 32'h4008); // audio transmit on source 14
        pulse(13'h400, 0);
        rd(8'h0c, 32'h4048); // usb pending on source 6
        wr(8'h20, 32'h80);
        pulse(13'h800, 0);
        rd(8'h0c, 32'h6048); // usb resume via port 0 pin 7
        wr(8'h00, 32'h80);
        wr(8'h08, 32'h0a);
        settle;
        req(1, 6); // shared port 2 vector
        wr(8'h08, 32'h08);
        wr(8'h04, 32'h20);
        settle;
        req(1, 13); // port 0 vector for resume
        wr(8'h04, 0);
        settle;
        req(1, 14); // shared serial transmit vector
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // acknowledge count and hang guard
    always @(posedge clk)
    begin
        n_ack += ack;
        cyc++;
        if (cyc == 4000)
        begin
            n_errors++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_regs;
        t_gate;
        t_mev;
        t_wdog;
        t_shared;
        give_verdict;
    end
endmodule // cim_top_tb
